// ### include/prib_pkg.sv
package prib_pkg;
    localparam int PC_W = 21;
    localparam int SP_W = 5;
    localparam int DATA_W = 8;
    localparam int PIXEL_NUM = 6;
    localparam int SEG_NUM = 6;
    localparam int FLAG_W = 8;
    localparam logic [PC_W-1:0] HIGH_VECTOR = 21'h000008;
    localparam logic [PC_W-1:0] LOW_VECTOR = 21'h000018;
    localparam logic [DATA_W-1:0] ZERO_INIT = 8'h00;
    localparam logic [DATA_W-1:0] COMP_CTRL_INIT = 8'h07;
    localparam logic [DATA_W-1:0] TX_STAT_INIT = 8'h02;
    localparam logic [DATA_W-1:0] CONV_FIRST_MASK = 8'hBF;
    localparam logic [DATA_W-1:0] CONV_SECOND_MASK = 8'h3F;
    localparam logic [DATA_W-1:0] CONV_THIRD_MASK = 8'hBF;
    localparam logic [DATA_W-1:0] DISP_CTRL_MASK = 8'hEF;
    localparam logic [DATA_W-1:0] RX_STAT_KEEP_MASK = 8'h01;
    localparam logic [SP_W-1:0] SP_ZERO = 5'h00;
    localparam logic [SP_W-1:0] SP_STEP = 5'h01;
    localparam logic [FLAG_W-1:0] FLAG_ZERO = 8'h00;
    typedef enum logic [4:0] {
        PRIB_CONV_HIGH, PRIB_CONV_LOW, PRIB_CONV_FIRST, PRIB_CONV_SECOND, PRIB_CONV_THIRD,
        PRIB_PIXEL, PRIB_SEGMENT, PRIB_PHASE, PRIB_DISP_CTRL, PRIB_VREF, PRIB_COMP,
        PRIB_TMR_HIGH, PRIB_TMR_LOW, PRIB_TMR_CTRL, PRIB_BAUD, PRIB_RX_BUF, PRIB_TX_BUF,
        PRIB_TX_STAT, PRIB_RX_STAT
    } prib_reg_sel_t;
    localparam logic [4:0] PIXEL_BASE = 5'h13;
endpackage : prib_pkg

// ### design/prib_bank.sv
`timescale 1ns/1ps
// Operation
// RQ1 - Conversion result bytes are unknown after power-on, kept otherwise.
// RQ2 - First converter control clears on both reset classes; bit 6 absent; wake keeps.
// RQ3 - Second converter control has six bits, cleared on resets, kept on wake.
// RQ4 - Third converter control clears on resets, bit 6 absent, kept on wake.
// RQ5 - Pixel data registers unknown after power-on, kept through everything else.
// RQ6 - Segment enables clear only on power-on, kept on other resets and wake.
// RQ7 - Phase and prescale register clears on both resets, kept on wake.
// RQ8 - Display control clears on both resets, kept on wake; bit 4 absent.
// RQ9 - Comparator reference control clears on both resets, kept on wake.
// RQ10 - Comparator control loads 0000 0111 on both resets, kept on wake.
// RQ11 - Third timer count bytes unknown after power-on, kept otherwise.
// RQ12 - Third timer control clears on power-on only, kept otherwise.
// RQ13 - Baud divisor and serial buffers clear on both resets, kept on wake.
// RQ14 - Transmit status loads 0000 0010 on both resets, kept on wake.
// RQ15 - Receive status clears bits 7..1 on resets, bit 0 unchanged, kept on wake.
// RQ16 - Unimplemented bit positions always read zero.
// RQ17 - Interrupt wake with a global enable pushes the program counter, bumps pointer.
// RQ18 - Such a wake loads the program counter with vector 0008h or 0018h.
// RQ19 - Every wake sets at least one cause flag bit.
// RQ20 - Reset class arrives one-hot for one clock from the sequencer.
module prib_bank (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic power_on_reset_i,
    input wire logic other_reset_i,
    input wire logic wake_i,
    input wire logic wake_by_interrupt_i,
    input wire logic wake_high_priority_i,
    input wire logic high_priority_global_enable_i,
    input wire logic low_priority_global_enable_i,
    input wire logic [prib_pkg::FLAG_W-1:0] wake_cause_flags_i,
    input wire logic [prib_pkg::PC_W-1:0] pc_i,
    input wire logic write_en_i,
    input wire logic [4:0] write_sel_i,
    input wire logic [prib_pkg::DATA_W-1:0] write_data_i,
    input wire logic [4:0] read_sel_i,
    output logic [prib_pkg::DATA_W-1:0] read_data_o,
    output logic pc_load_o,
    output logic [prib_pkg::PC_W-1:0] pc_load_value_o,
    output logic [prib_pkg::PC_W-1:0] stack_top_o,
    output logic [prib_pkg::SP_W-1:0] stack_pointer_reg_o,
    output logic [prib_pkg::FLAG_W-1:0] peripheral_request_flags_o
);
    import prib_pkg::*;

    logic por_ev;
    logic oth_ev;
    logic any_rst;
    logic [DATA_W-1:0] conv_result_high_reg;
    logic [DATA_W-1:0] conv_result_low_reg;
    logic [DATA_W-1:0] conv_control_first_reg;
    logic [DATA_W-1:0] conv_control_second_reg;
    logic [DATA_W-1:0] conv_control_third_reg;
    logic [DATA_W-1:0] display_pixel_data_reg [PIXEL_NUM];
    logic [DATA_W-1:0] display_segment_enable_reg [SEG_NUM];
    logic [DATA_W-1:0] display_phase_prescale_reg;
    logic [DATA_W-1:0] display_control_reg;
    logic [DATA_W-1:0] comparator_vref_control_reg;
    logic [DATA_W-1:0] comparator_control_reg;
    logic [DATA_W-1:0] third_timer_count_high_reg;
    logic [DATA_W-1:0] third_timer_count_low_reg;
    logic [DATA_W-1:0] third_timer_control_reg;
    logic [DATA_W-1:0] serial_baud_divisor_reg;
    logic [DATA_W-1:0] serial_receive_buffer_reg;
    logic [DATA_W-1:0] serial_transmit_buffer_reg;
    logic [DATA_W-1:0] serial_tx_status_control_reg;
    logic [DATA_W-1:0] serial_rx_status_control_reg;
    logic [PC_W-1:0] stack_top_reg;
    logic [SP_W-1:0] stack_pointer_reg;
    logic [FLAG_W-1:0] flags_reg;
    logic pc_load_reg;
    logic [PC_W-1:0] pc_load_value_reg;
    logic [DATA_W-1:0] read_data_reg;
    logic int_wake;
    logic [DATA_W-1:0] read_next;
    logic wake_ev;
    logic [SP_W-1:0] stack_pointer_next;
    logic [PC_W-1:0] vector_next;

    // Sequencer classes; reset_n_i acts as power-on
    assign por_ev = !reset_n_i || power_on_reset_i; // RQ20
    assign oth_ev = reset_n_i && !power_on_reset_i && other_reset_i; // RQ20
    assign any_rst = por_ev || oth_ev;
    assign wake_ev = reset_n_i && !any_rst && wake_i;
    assign int_wake = wake_ev && wake_by_interrupt_i
        && (high_priority_global_enable_i || low_priority_global_enable_i); // RQ17
    assign stack_pointer_next = stack_pointer_reg + SP_STEP;
    assign vector_next = wake_high_priority_i ? HIGH_VECTOR : LOW_VECTOR; // RQ18

    // Write strobe for one select code
    function automatic logic wr(input logic [4:0] sel);
        wr = write_en_i && (write_sel_i == sel);
    endfunction : wr

    // Undefined-at-power-on bytes: no reset load at all
    always_ff @(posedge clock_i) begin
        if (wr(PRIB_CONV_HIGH)) begin // RQ1
            conv_result_high_reg <= write_data_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (wr(PRIB_CONV_LOW)) begin // RQ1
            conv_result_low_reg <= write_data_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (wr(PRIB_TMR_HIGH)) begin // RQ11
            third_timer_count_high_reg <= write_data_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (wr(PRIB_TMR_LOW)) begin // RQ11
            third_timer_count_low_reg <= write_data_i;
        end
    end

    // Pixel and segment banks
    genvar gi;
    generate
        for (gi = 0; gi < PIXEL_NUM; gi++) begin : g_disp
            always_ff @(posedge clock_i) begin
                if (write_en_i && write_sel_i == 5'(PIXEL_BASE + gi)) begin // RQ5
                    display_pixel_data_reg[gi] <= write_data_i;
                end
            end
            always_ff @(posedge clock_i) begin
                if (por_ev) begin
                    display_segment_enable_reg[gi] <= ZERO_INIT; // RQ6
                end else if (write_en_i && write_sel_i == 5'(PIXEL_BASE + PIXEL_NUM + gi))
                begin
                    display_segment_enable_reg[gi] <= write_data_i;
                end
            end
        end
    endgenerate

    // Cleared on power-on only
    always_ff @(posedge clock_i) begin
        if (por_ev) begin
            third_timer_control_reg <= ZERO_INIT; // RQ12
        end else if (wr(PRIB_TMR_CTRL)) begin
            third_timer_control_reg <= write_data_i;
        end
    end

    // Loaded on both non-wake classes, kept on wake
    always_ff @(posedge clock_i) begin
        if (any_rst) begin
            conv_control_first_reg <= ZERO_INIT; // RQ2
        end else if (wr(PRIB_CONV_FIRST)) begin
            conv_control_first_reg <= write_data_i & CONV_FIRST_MASK; // RQ16
        end
    end

    always_ff @(posedge clock_i) begin
        if (any_rst) begin
            conv_control_second_reg <= ZERO_INIT; // RQ3
        end else if (wr(PRIB_CONV_SECOND)) begin
            conv_control_second_reg <= write_data_i & CONV_SECOND_MASK; // RQ16
        end
    end

    always_ff @(posedge clock_i) begin
        if (any_rst) begin
            conv_control_third_reg <= ZERO_INIT; // RQ4
        end else if (wr(PRIB_CONV_THIRD)) begin
            conv_control_third_reg <= write_data_i & CONV_THIRD_MASK; // RQ16
        end
    end

    always_ff @(posedge clock_i) begin
        if (any_rst) begin
            display_phase_prescale_reg <= ZERO_INIT; // RQ7
        end else if (wr(PRIB_PHASE)) begin
            display_phase_prescale_reg <= write_data_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (any_rst) begin
            display_control_reg <= ZERO_INIT; // RQ8
        end else if (wr(PRIB_DISP_CTRL)) begin
            display_control_reg <= write_data_i & DISP_CTRL_MASK; // RQ16
        end
    end

    always_ff @(posedge clock_i) begin
        if (any_rst) begin
            comparator_vref_control_reg <= ZERO_INIT; // RQ9
        end else if (wr(PRIB_VREF)) begin
            comparator_vref_control_reg <= write_data_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (any_rst) begin
            comparator_control_reg <= COMP_CTRL_INIT; // RQ10
        end else if (wr(PRIB_COMP)) begin
            comparator_control_reg <= write_data_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (any_rst) begin
            serial_baud_divisor_reg <= ZERO_INIT; // RQ13
        end else if (wr(PRIB_BAUD)) begin
            serial_baud_divisor_reg <= write_data_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (any_rst) begin
            serial_receive_buffer_reg <= ZERO_INIT; // RQ13
        end else if (wr(PRIB_RX_BUF)) begin
            serial_receive_buffer_reg <= write_data_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (any_rst) begin
            serial_transmit_buffer_reg <= ZERO_INIT; // RQ13
        end else if (wr(PRIB_TX_BUF)) begin
            serial_transmit_buffer_reg <= write_data_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (any_rst) begin
            serial_tx_status_control_reg <= TX_STAT_INIT; // RQ14
        end else if (wr(PRIB_TX_STAT)) begin
            serial_tx_status_control_reg <= write_data_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (any_rst) begin
            serial_rx_status_control_reg <=
                serial_rx_status_control_reg & RX_STAT_KEEP_MASK; // RQ15
        end else if (wr(PRIB_RX_STAT)) begin
            serial_rx_status_control_reg <= write_data_i;
        end
    end

    // Interrupt wake: push and vector
    always_ff @(posedge clock_i) begin
        if (any_rst) begin
            stack_top_reg <= {PC_W{1'b0}};
        end else if (int_wake) begin
            stack_top_reg <= pc_i; // RQ17
        end
    end

    always_ff @(posedge clock_i) begin
        if (any_rst) begin
            stack_pointer_reg <= SP_ZERO;
        end else if (int_wake) begin
            stack_pointer_reg <= stack_pointer_next; // RQ17
        end
    end

    // Vector load pulse
    always_ff @(posedge clock_i) begin
        if (any_rst) begin
            pc_load_reg <= 1'b0;
        end else begin
            pc_load_reg <= int_wake; // RQ18
        end
    end

    always_ff @(posedge clock_i) begin
        if (any_rst) begin
            pc_load_value_reg <= {PC_W{1'b0}};
        end else if (int_wake) begin
            pc_load_value_reg <= vector_next; // RQ18
        end
    end

    // Wake cause flags; ORed in on wake, cleared by resets, reset wins
    always_ff @(posedge clock_i) begin
        if (any_rst) begin
            flags_reg <= FLAG_ZERO;
        end else if (wake_ev) begin
            flags_reg <= flags_reg | ((wake_cause_flags_i == FLAG_ZERO) ?
                {{(FLAG_W-1){1'b0}}, 1'b1} : wake_cause_flags_i); // RQ19
        end
    end

    // Read path
    always_comb begin
        read_next = ZERO_INIT;
        case (read_sel_i)
            PRIB_CONV_HIGH: read_next = conv_result_high_reg;
            PRIB_CONV_LOW: read_next = conv_result_low_reg;
            PRIB_CONV_FIRST: read_next = conv_control_first_reg & CONV_FIRST_MASK; // RQ16
            PRIB_CONV_SECOND: read_next = conv_control_second_reg & CONV_SECOND_MASK; // RQ16
            PRIB_CONV_THIRD: read_next = conv_control_third_reg & CONV_THIRD_MASK; // RQ16
            PRIB_PHASE: read_next = display_phase_prescale_reg;
            PRIB_DISP_CTRL: read_next = display_control_reg & DISP_CTRL_MASK; // RQ16
            PRIB_VREF: read_next = comparator_vref_control_reg;
            PRIB_COMP: read_next = comparator_control_reg;
            PRIB_TMR_HIGH: read_next = third_timer_count_high_reg;
            PRIB_TMR_LOW: read_next = third_timer_count_low_reg;
            PRIB_TMR_CTRL: read_next = third_timer_control_reg;
            PRIB_BAUD: read_next = serial_baud_divisor_reg;
            PRIB_RX_BUF: read_next = serial_receive_buffer_reg;
            PRIB_TX_BUF: read_next = serial_transmit_buffer_reg;
            PRIB_TX_STAT: read_next = serial_tx_status_control_reg;
            PRIB_RX_STAT: read_next = serial_rx_status_control_reg;
            default: begin
                for (int k = 0; k < PIXEL_NUM; k++) begin
                    if (read_sel_i == 5'(PIXEL_BASE + k)) begin
                        read_next = display_pixel_data_reg[k];
                    end
                    if (read_sel_i == 5'(PIXEL_BASE + PIXEL_NUM + k)) begin
                        read_next = display_segment_enable_reg[k];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            read_data_reg <= ZERO_INIT;
        end else begin
            read_data_reg <= read_next;
        end
    end

    // Outputs
    assign read_data_o = read_data_reg;
    assign pc_load_o = pc_load_reg;
    assign pc_load_value_o = pc_load_value_reg;
    assign stack_top_o = stack_top_reg;
    assign stack_pointer_reg_o = stack_pointer_reg;
    assign peripheral_request_flags_o = flags_reg;
endmodule : prib_bank

// ### tb/prib_bank_assertions.sv
`timescale 1ns/1ps
module prib_bank_assertions
    import prib_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic power_on_reset_i,
    input wire logic other_reset_i,
    input wire logic wake_i,
    input wire logic wake_by_interrupt_i,
    input wire logic wake_high_priority_i,
    input wire logic high_priority_global_enable_i,
    input wire logic low_priority_global_enable_i,
    input wire logic [prib_pkg::FLAG_W-1:0] wake_cause_flags_i,
    input wire logic [prib_pkg::PC_W-1:0] pc_i,
    input wire logic [4:0] read_sel_i,
    input wire logic [prib_pkg::DATA_W-1:0] read_data_o,
    input wire logic pc_load_o,
    input wire logic [prib_pkg::PC_W-1:0] pc_load_value_o,
    input wire logic [prib_pkg::PC_W-1:0] stack_top_o,
    input wire logic [prib_pkg::SP_W-1:0] stack_pointer_reg_o,
    input wire logic [prib_pkg::FLAG_W-1:0] peripheral_request_flags_o
);
    wire logic woke = wake_i && !power_on_reset_i && !other_reset_i;
    wire logic en = high_priority_global_enable_i || low_priority_global_enable_i;
    wire logic push = woke && wake_by_interrupt_i && en;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    a_high_vector_load: assert property (push && wake_high_priority_i |=>
        pc_load_o && pc_load_value_o == HIGH_VECTOR) else $error("high vector not loaded");
    a_low_vector_load: assert property (push && !wake_high_priority_i |=>
        pc_load_o && pc_load_value_o == LOW_VECTOR) else $error("low vector not loaded");
    a_stack_top_push: assert property (push |=> stack_top_o == $past(pc_i) &&
        stack_pointer_reg_o == $past(stack_pointer_reg_o) + SP_STEP) else $error("push wrong");
    a_no_push_plain: assert property (woke && !push |=>
        !pc_load_o && $stable(stack_pointer_reg_o)) else $error("push without enable");
    a_load_needs_wake: assert property (pc_load_o |-> $past(push))
        else $error("stray vector load");
    a_wake_sets_flags: assert property (woke |=> peripheral_request_flags_o != FLAG_ZERO &&
        (peripheral_request_flags_o & $past(wake_cause_flags_i)) == $past(wake_cause_flags_i))
        else $error("wake flags missing");
    a_reset_clears_state: assert property (other_reset_i |=>
        peripheral_request_flags_o == FLAG_ZERO && stack_pointer_reg_o == SP_ZERO)
        else $error("reset left stack or flags");
    a_second_top_zero: assert property (read_sel_i == PRIB_CONV_SECOND |=>
        read_data_o[7:6] == 2'b00) else $error("absent bits read nonzero");
    a_display_bit_zero: assert property (read_sel_i == PRIB_DISP_CTRL |=>
        read_data_o[4] == 1'b0) else $error("absent display bit nonzero");
endmodule : prib_bank_assertions
bind prib_bank prib_bank_assertions chk (.*);

// ### tb/prib_seq_model.sv
`timescale 1ns/1ps
module prib_seq_model (
    input wire logic clock_i,
    output logic power_on_reset_o,
    output logic other_reset_o,
    output logic wake_o,
    output logic wake_by_interrupt_o,
    output logic wake_high_priority_o
);
    initial begin
        {power_on_reset_o, other_reset_o, wake_o} = 3'h0;
        {wake_by_interrupt_o, wake_high_priority_o} = 2'h0;
    end
    // One-hot class pulse for a single clock
    task automatic pulse(input logic [2:0] k, input logic irq, input logic hi);
        @(posedge clock_i) #1;
        {power_on_reset_o, other_reset_o, wake_o} = k;
        {wake_by_interrupt_o, wake_high_priority_o} = {irq, hi};
        @(posedge clock_i) #1;
        {power_on_reset_o, other_reset_o, wake_o} = 3'h0;
        {wake_by_interrupt_o, wake_high_priority_o} = 2'h0;
    endtask : pulse
endmodule : prib_seq_model

// ### tb/tb_peripheral_reset_init_bank.sv
`timescale 1ns/1ps
module tb_peripheral_reset_init_bank;
    import prib_pkg::*;
    logic clock_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic power_on_reset_i, other_reset_i, wake_i, wake_by_interrupt_i, wake_high_priority_i;
    logic high_priority_global_enable_i = 1'b0;
    logic low_priority_global_enable_i = 1'b0;
    logic [FLAG_W-1:0] wake_cause_flags_i = FLAG_ZERO;
    logic [PC_W-1:0] pc_i = 21'h000000;
    logic write_en_i = 1'b0;
    logic [4:0] write_sel_i = 5'h00;
    logic [DATA_W-1:0] write_data_i = 8'h00;
    logic [4:0] read_sel_i = 5'h00;
    logic [DATA_W-1:0] read_data_o;
    logic pc_load_o;
    logic [PC_W-1:0] pc_load_value_o, stack_top_o;
    logic [SP_W-1:0] stack_pointer_reg_o, sp_exp;
    logic [FLAG_W-1:0] peripheral_request_flags_o, fl_exp;
    logic [DATA_W-1:0] mdl [31];
    logic [127:0] exp_q [$];
    logic [127:0] nx;
    logic [63:0] obs;
    logic q;
    int fails = 0;
    int compares = 0;
    always #4 clock_i = ~clock_i;
    prib_bank dut (.*);
    prib_seq_model seq (.clock_i(clock_i), .power_on_reset_o(power_on_reset_i),
        .other_reset_o(other_reset_i), .wake_o(wake_i), .wake_by_interrupt_o(wake_by_interrupt_i),
        .wake_high_priority_o(wake_high_priority_i));
    function automatic logic [7:0] msk(input int c);
        case (c)
            PRIB_CONV_FIRST: return CONV_FIRST_MASK;
            PRIB_CONV_SECOND: return CONV_SECOND_MASK;
            PRIB_CONV_THIRD: return CONV_THIRD_MASK;
            PRIB_DISP_CTRL: return DISP_CTRL_MASK;
            default: return 8'hFF;
        endcase
    endfunction : msk
    task automatic rst_model(input bit por);
        for (int c = 0; c < 31; c++) begin
            if (c == PRIB_RX_STAT) mdl[c] &= RX_STAT_KEEP_MASK;
            else if (c == PRIB_TMR_CTRL || c >= PIXEL_BASE + PIXEL_NUM)
                mdl[c] = por ? ZERO_INIT : mdl[c];
            else if (!(c inside {0, 1, 11, 12}) && c < PIXEL_BASE)
                mdl[c] = (c == PRIB_COMP) ? COMP_CTRL_INIT :
                    (c == PRIB_TX_STAT) ? TX_STAT_INIT : ZERO_INIT;
        end
        sp_exp = SP_ZERO;
        fl_exp = FLAG_ZERO;
        exp_q.push_back({43'h0, 13'h1FFF, 8'h00, 43'h0, sp_exp, fl_exp, 8'h00});
    endtask : rst_model
    task automatic wr_all;
        for (int c = 0; c < 31; c++) begin
            if (c != 5 && c != 6) begin
                @(posedge clock_i) #1;
                write_en_i = 1'b1;
                write_sel_i = 5'(c);
                write_data_i = 8'($urandom);
                mdl[c] = write_data_i & msk(c);
            end
        end
        @(posedge clock_i) #1 write_en_i = 1'b0;
    endtask : wr_all
    task automatic rd_all;
        for (int c = 0; c < 31; c++) begin
            if (c != 5 && c != 6) begin
                @(posedge clock_i) #1 read_sel_i = 5'(c);
                @(posedge clock_i) #1 exp_q.push_back({64'hFF, 56'h0, mdl[c]});
            end
        end
    endtask : rd_all
    task automatic final_report;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : final_report
    always @(negedge clock_i) begin
        while (exp_q.size() > 0) begin
            nx = exp_q.pop_front();
            obs = {pc_load_o, pc_load_value_o, stack_top_o, stack_pointer_reg_o,
                peripheral_request_flags_o, read_data_o};
            compares++;
            if (((obs ^ nx[63:0]) & nx[127:64]) !== 64'h0) begin
                fails++;
                $display("unexpected at %0t got %h exp %h", $time, obs & nx[127:64], nx[63:0]);
            end
        end
    end
    initial begin
        #200000;
        fails++;
        final_report();
    end
    initial begin
        void'($urandom(32'h3E4D1C7B));
        repeat (6) @(posedge clock_i);
        #1 reset_n_i = 1'b1;
        wr_all();
        rd_all();
        for (int r = 0; r < 2; r++) begin
            for (int i = 0; i < 8; i++) begin
                {low_priority_global_enable_i, high_priority_global_enable_i} = 2'(i);
                pc_i = 21'($urandom);
                wake_cause_flags_i = (i == 4) ? FLAG_ZERO : 8'($urandom);
                q = (i != 7) && (i[1:0] != 2'b00);
                seq.pulse(3'b001, i != 7, i[2]);
                sp_exp = sp_exp + (q ? SP_STEP : SP_ZERO);
                fl_exp |= (wake_cause_flags_i == FLAG_ZERO) ? 8'h01 : wake_cause_flags_i;
                exp_q.push_back({1'b1, {42{q}}, 13'h1FFF, 8'h00, q,
                    i[2] ? HIGH_VECTOR : LOW_VECTOR,
                    pc_i, sp_exp, fl_exp, 8'h00});
            end
            rd_all();
            seq.pulse((r == 0) ? 3'b010 : 3'b100, 1'b0, 1'b0);
            rst_model(r != 0);
            rd_all();
            wr_all();
        end
        final_report();
    end
endmodule : tb_peripheral_reset_init_bank
